// *** design/lcpc_defs.svh ***
`ifndef LCPC_DEFS_SVH
`define LCPC_DEFS_SVH

// byte addresses on the register bus
`define LCPC_ADDR_CPC 8'h00
`define LCPC_ADDR_STATUS 8'h04
`define LCPC_ADDR_BIE 8'h20

// channel power control fields
`define LCPC_TX_CH0_BIT 0
`define LCPC_TX_CH1_BIT 1
`define LCPC_TX_CH2_BIT 2
`define LCPC_RSVD3_BIT 3
`define LCPC_RX_CH0_BIT 4
`define LCPC_RX_CH1_BIT 5
`define LCPC_RX_CH2_BIT 6
`define LCPC_TX_LSB 0
`define LCPC_TX_MSB 2
`define LCPC_RX_LSB 4
`define LCPC_RX_MSB 6
`define LCPC_CPC_WMASK 8'h77
`define LCPC_CPC_RESET 8'h00

// block interrupt enable fields
`define LCPC_BIE_WMASK 8'h07
`define LCPC_BIE_RESET 8'h00

// status register fields
`define LCPC_ST_PIN_LSB 0
`define LCPC_ST_DRV_LSB 4

`endif

// *** design/lcpc_pkg.sv ***
package lcpc_pkg;

   typedef enum logic {
      LCPC_APB_IDLE,
      LCPC_APB_ACCESS
   } lcpc_apb_state_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } lcpc_apb_req_type;

   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
   } lcpc_line_type;

   typedef struct packed {
      lcpc_apb_state_type apb;
      logic [7:0] cpc;
      logic [7:0] bie;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      lcpc_line_type rx_s1;
      lcpc_line_type rx_s2;
      lcpc_line_type rx_out;
      lcpc_line_type tx_out;
      logic [2:0] tx_oe;
      logic [2:0] rx_on;
   } lcpc_state_type;

endpackage

// *** design/lcpc_top.sv ***
// Overview of operation
// - clearing bit 5 shuts off the channel 1 receive section, setting it turns it on.
// - an enabled receive section passes its line input pair through to the data side.
// - a receive section that is off has its data outputs gated, so its outputs rest at zero.
// - bit 4 turns the channel 0 receive section on when set and off when cleared.
// - clearing bit 2 disables the channel 2 driver and floats both of its line outputs.
// - a set transmit bit, with that channel's driver enable pin high, enables that driver and sends line pulses on its output pair.
// - bit 1 enables the channel 1 driver when set with its enable pin high and floats both its outputs when cleared.
// - bit 0 enables the channel 0 driver when set with its enable pin high and floats both its outputs when cleared.
`timescale 1ns/1ps
`include "lcpc_defs.svh"

module lcpc_top #(
   parameter int CHANNELS = 3
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // driver enable pins, asynchronous
   input wire logic [2:0] DRIVER_ENABLE_PIN,
   // receive line pairs, asynchronous
   input wire logic [2:0] LINE_RX_POSITIVE,
   input wire logic [2:0] LINE_RX_NEGATIVE,
   // recovered receive data
   output logic [2:0] RX_DATA_POSITIVE,
   output logic [2:0] RX_DATA_NEGATIVE,
   // receive section power
   output logic [2:0] RX_SECTION_ON,
   // transmit data from the terminal side, same clock
   input wire logic [2:0] TX_DATA_POSITIVE,
   input wire logic [2:0] TX_DATA_NEGATIVE,
   // transmit line pairs with output enable
   output logic [2:0] LINE_TX_POSITIVE,
   output logic [2:0] LINE_TX_NEGATIVE,
   output logic [2:0] LINE_TX_OE,
   // block interrupt enable bits, storage only
   output logic [2:0] BLOCK_INTERRUPT_ENABLE
);

   lcpc_pkg::lcpc_state_type s_q;
   lcpc_pkg::lcpc_state_type s_d;
   lcpc_pkg::lcpc_apb_req_type req;
   logic [2:0] drive_on;

   assign req.psel = PSEL;
   assign req.penable = PENABLE;
   assign req.pwrite = PWRITE;
   assign req.paddr = PADDR;
   assign req.pwdata = PWDATA;

   // driver runs only with both the register bit and the synced pin high
   assign drive_on = s_q.cpc[`LCPC_TX_MSB:`LCPC_TX_LSB] & s_q.pin_s2;

   // read value of each mapped register, zero above the 8 data bits
   function automatic logic [31:0] read_value(
      input logic [7:0] addr,
      input logic [7:0] cpc,
      input logic [7:0] bie,
      input logic [2:0] pins,
      input logic [2:0] drv
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      case (addr)
         `LCPC_ADDR_CPC: begin
            v[7:0] = cpc & `LCPC_CPC_WMASK;
         end
         `LCPC_ADDR_BIE: begin
            v[7:0] = bie & `LCPC_BIE_WMASK;
         end
         `LCPC_ADDR_STATUS: begin
            v[`LCPC_ST_PIN_LSB +: 3] = pins;
            v[`LCPC_ST_DRV_LSB +: 3] = drv;
         end
         default: begin
            v = 32'h0000_0000;
         end
      endcase
      return v;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] addr);
      logic ok;
      ok = (addr == `LCPC_ADDR_CPC) || (addr == `LCPC_ADDR_BIE) ||
           (addr == `LCPC_ADDR_STATUS);
      return ok;
   endfunction

   always_comb begin
      s_d = s_q;

      // two-flop synchronisers for the driver enable pins and the receive line pairs
      s_d.pin_s1 = DRIVER_ENABLE_PIN;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.rx_s1.pos = LINE_RX_POSITIVE;
      s_d.rx_s1.neg = LINE_RX_NEGATIVE;
      s_d.rx_s2 = s_q.rx_s1;

      // apb: answer is prepared in setup, so access always has no wait
      case (s_q.apb)
         lcpc_pkg::LCPC_APB_IDLE: begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            if (req.psel && !req.penable) begin
               s_d.apb = lcpc_pkg::LCPC_APB_ACCESS;
               s_d.pready = 1'b1;
               s_d.pslverr = !addr_mapped(req.paddr);
               s_d.prdata = 32'h0000_0000;
               if (!req.pwrite) begin
                  s_d.prdata = read_value(req.paddr, s_q.cpc, s_q.bie,
                                          s_q.pin_s2, drive_on);
               end
            end
         end
         lcpc_pkg::LCPC_APB_ACCESS: begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
            s_d.apb = lcpc_pkg::LCPC_APB_IDLE;
            if (req.psel && req.penable && req.pwrite) begin
               case (req.paddr)
                  `LCPC_ADDR_CPC: begin
                     // reserved bits 3 and 7 never take a write
                     s_d.cpc = req.pwdata[7:0] & `LCPC_CPC_WMASK;
                  end
                  `LCPC_ADDR_BIE: begin
                     s_d.bie = req.pwdata[7:0] & `LCPC_BIE_WMASK;
                  end
                  default: begin
                     s_d.cpc = s_q.cpc;
                  end
               endcase
            end
         end
         default: begin
            s_d.apb = lcpc_pkg::LCPC_APB_IDLE;
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
         end
      endcase

      // receive section power follows bits 6:4
      s_d.rx_on[0] = s_q.cpc[`LCPC_RX_CH0_BIT];
      s_d.rx_on[1] = s_q.cpc[`LCPC_RX_CH1_BIT];
      s_d.rx_on[2] = s_q.cpc[`LCPC_RX_CH2_BIT];

      // powered-down path holds its outputs low instead of random data
      s_d.rx_out.pos = s_q.rx_s2.pos & s_q.rx_on;
      s_d.rx_out.neg = s_q.rx_s2.neg & s_q.rx_on;

      // transmit driver: data only while enabled, otherwise floated
      s_d.tx_oe[0] = drive_on[`LCPC_TX_CH0_BIT];
      s_d.tx_oe[1] = drive_on[`LCPC_TX_CH1_BIT];
      s_d.tx_oe[2] = drive_on[`LCPC_TX_CH2_BIT];
      s_d.tx_out.pos = TX_DATA_POSITIVE & drive_on;
      s_d.tx_out.neg = TX_DATA_NEGATIVE & drive_on;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q <= '0;
         s_q.cpc <= `LCPC_CPC_RESET;
         s_q.bie <= `LCPC_BIE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign RX_DATA_POSITIVE = s_q.rx_out.pos;
   assign RX_DATA_NEGATIVE = s_q.rx_out.neg;
   assign RX_SECTION_ON = s_q.rx_on;
   assign LINE_TX_POSITIVE = s_q.tx_out.pos;
   assign LINE_TX_NEGATIVE = s_q.tx_out.neg;
   assign LINE_TX_OE = s_q.tx_oe;
   assign BLOCK_INTERRUPT_ENABLE = s_q.bie[2:0];

endmodule

// *** tb/lcpc_assertions.sv ***
`timescale 1ns/1ps
`include "lcpc_defs.svh"
module lcpc_assertions (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // line side
   input wire logic [2:0] DRIVER_ENABLE_PIN,
   input wire logic [2:0] LINE_RX_POSITIVE,
   input wire logic [2:0] RX_DATA_POSITIVE,
   input wire logic [2:0] RX_DATA_NEGATIVE,
   input wire logic [2:0] RX_SECTION_ON,
   input wire logic [2:0] TX_DATA_POSITIVE,
   input wire logic [2:0] LINE_TX_POSITIVE,
   input wire logic [2:0] LINE_TX_NEGATIVE,
   input wire logic [2:0] LINE_TX_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // answer stands exactly one cycle
   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence
   a_bus_answer: assert property (PSEL && !PENABLE |=> s_answer)
      else $error("bus answer wrong");
   a_idle_quiet: assert property (!PSEL |=> !PREADY)
      else $error("ready without select");
   a_err_unmapped: assert property (PREADY |-> PSLVERR == !(PADDR inside
      {`LCPC_ADDR_CPC, `LCPC_ADDR_STATUS, `LCPC_ADDR_BIE}))
      else $error("slave error wrong");
   a_rsvd_zero: assert property (PREADY && !PWRITE &&
      PADDR == `LCPC_ADDR_CPC |-> PRDATA[31:7] == 0 && !PRDATA[3])
      else $error("reserved bits not zero");
   a_off_float: assert property (((LINE_TX_POSITIVE |
      LINE_TX_NEGATIVE) & ~LINE_TX_OE) == 3'h0)
      else $error("disabled driver shows data");
   a_oe_pin: assert property ((LINE_TX_OE &
      ~$past(DRIVER_ENABLE_PIN, 3)) == 3'h0)
      else $error("driver on with pin low");
   a_tx_pass: assert property ((LINE_TX_POSITIVE & LINE_TX_OE) ==
      ($past(TX_DATA_POSITIVE) & LINE_TX_OE))
      else $error("transmit data lost");
   a_rx_quiet: assert property (((RX_DATA_POSITIVE |
      RX_DATA_NEGATIVE) & ~$past(RX_SECTION_ON)) == 3'h0)
      else $error("receive path not quiet");
   a_rx_pass: assert property ((RX_DATA_POSITIVE &
      $past(RX_SECTION_ON)) == ($past(LINE_RX_POSITIVE, 3) &
      $past(RX_SECTION_ON)))
      else $error("receive data lost");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "lcpc_defs.svh"
module tb;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [2:0] DRIVER_ENABLE_PIN = 3'h0;
   logic [7:0] pat = 8'h00;
   wire [2:0] TX_DATA_POSITIVE = pat[2:0];
   wire [2:0] TX_DATA_NEGATIVE = ~pat[2:0];
   wire [2:0] LINE_RX_POSITIVE = pat[5:3];
   wire [2:0] LINE_RX_NEGATIVE = ~pat[5:3];
   logic [31:0] PRDATA, rd;
   logic PREADY, PSLVERR, er;
   logic [2:0] RX_DATA_POSITIVE, RX_DATA_NEGATIVE, RX_SECTION_ON;
   logic [2:0] LINE_TX_POSITIVE, LINE_TX_NEGATIVE, LINE_TX_OE;
   logic [2:0] BLOCK_INTERRUPT_ENABLE;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   lcpc_top dut (.*);
   always #20 CLK = ~CLK;
   always @(posedge CLK) begin
      pat <= pat + 8'h01;
      cyc <= cyc + 1;
      // ceiling well above the fewer than one hundred cycles needed
      if (cyc == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge CLK);
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      {PSEL, PENABLE} <= 2'b00;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      xfer(0, `LCPC_ADDR_CPC, 32'h0);
      chk("cpc_rst", rd, 32'h0);
      xfer(1, `LCPC_ADDR_CPC, 32'hFF);
      xfer(0, `LCPC_ADDR_CPC, 32'h0);
      chk("cpc_rd", rd, 32'h77);
      chk("rx_on", RX_SECTION_ON, 32'h7);
      chk("oe_nopin", LINE_TX_OE, 32'h0);
      $display("test 1 done");
      DRIVER_ENABLE_PIN <= 3'h7;
      for (int i = 0; i < 3; i++) begin
         xfer(1, `LCPC_ADDR_CPC, 32'h1 << i);
         // pin and register paths settle within three edges
         repeat (4) @(posedge CLK);
         chk("oe", LINE_TX_OE, 32'h1 << i);
         chk("rx_off", RX_SECTION_ON, 32'h0);
         chk("rxd_off", RX_DATA_POSITIVE, 32'h0);
         chk("rxn_off", RX_DATA_NEGATIVE, 32'h0);
      end
      xfer(0, `LCPC_ADDR_STATUS, 32'h0);
      chk("status", rd, 32'h47);
      // dropping the channel 2 pin must float its driver despite the bit
      DRIVER_ENABLE_PIN <= 3'h3;
      repeat (4) @(posedge CLK);
      chk("oe_pin_low", LINE_TX_OE, 32'h0);
      chk("txp_pin_low", LINE_TX_POSITIVE, 32'h0);
      chk("txn_pin_low", LINE_TX_NEGATIVE, 32'h0);
      $display("test 2 done");
      xfer(1, `LCPC_ADDR_CPC, 32'h18);
      repeat (4) @(posedge CLK);
      chk("rx0", RX_SECTION_ON, 32'h1);
      chk("rxd_hi", RX_DATA_POSITIVE[2:1], 32'h0);
      xfer(0, `LCPC_ADDR_CPC, 32'h0);
      chk("rsvd", rd, 32'h10);
      $display("test 3 done");
      xfer(1, `LCPC_ADDR_BIE, 32'hFF);
      xfer(0, `LCPC_ADDR_BIE, 32'h0);
      chk("bie", rd, 32'h7);
      chk("bie_out", BLOCK_INTERRUPT_ENABLE, 32'h7);
      xfer(0, 8'h08, 32'h0);
      chk("unmapped", {rd[30:0], er}, 32'h1);
      $display("test 4 done");
      stop_test();
   end
endmodule
bind lcpc_top lcpc_assertions chk_i (.*);
